// >>> rtl/dcfg_map.vh
// register map constants for the datapath configuration bank
// assumes registers are addressed by a small word address from the port
`ifndef DCFG_MAP_VH
`define DCFG_MAP_VH
// ****************
// addresses
// ****************
`define DCFG_ADDR_W 7
`define DCFG_ADDR_CTRL 7'h02
`define DCFG_ADDR_SCALE 7'h03
// ****************
// reset values
// ****************
`define DCFG_CTRL_RST 16'h7000
`define DCFG_SCALE_RST 16'hF000
// writable bit masks, reserved bits forced to zero
`define DCFG_CTRL_WMASK 16'hF0FA
`define DCFG_SCALE_WMASK 16'hF001
// ****************
// control register fields
// ****************
`define DCFG_B_WORD_WIDE 15
`define DCFG_B_DACCLK_SD 14
`define DCFG_B_DATACLK_SD 13
`define DCFG_B_COLL_SD 12
`define DCFG_B_FOUR_WIRE 7
`define DCFG_B_MIX_ENA 6
`define DCFG_B_MIX_GAIN 5
`define DCFG_B_OSC_ENA 4
`define DCFG_B_REV_BUS 3
`define DCFG_B_TWOS 1
// ****************
// scale register fields
// ****************
`define DCFG_F_SCALE_HI 15
`define DCFG_F_SCALE_LO 12
`define DCFG_B_SW_TX 0
// ****************
// alarm mask bits used by the shutdown gating
// ****************
`define DCFG_M_COLL 13
`define DCFG_M_DACCLK 10
`define DCFG_M_DATACLK 9
`define DCFG_M_OUTPUT 8
`endif

// >>> rtl/dcfg_sync2.v
// two-flop synchroniser for one asynchronous level
// assumes the input is a quasi-static pin level
`timescale 1ns/1ps
module dcfg_sync2
(
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // level in and out
  input wire din,
  output reg dout
);
  reg meta;
  // first flop feeds only the second
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // dcfg_sync2

// >>> rtl/dcfg_reg16.v
// one 16-bit read/write configuration register
// assumes write strobe and data on the clock domain
`timescale 1ns/1ps
`include "dcfg_map.vh"
module dcfg_reg16
#(
  parameter [15:0] RST_VAL = 16'h0000,
  parameter [15:0] WMASK = 16'hFFFF
)
(
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // write side
  input wire wr_en,
  input wire [15:0] wr_data,
  // contents
  output reg [15:0] value
);
  // reserved bits stay at zero whatever is written
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      value <= RST_VAL;
    else if (wr_en)
      value <= wr_data & WMASK;
  end
endmodule // dcfg_reg16

// >>> rtl/dcfg_regs.v
// datapath configuration register pair with decoded controls
// assumes a decoded serial-port write/read strobe on clock
`timescale 1ns/1ps
`include "dcfg_map.vh"
module dcfg_regs
#(
  parameter DW = 16
)
(
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // register access from the serial port
  input wire reg_wr,
  input wire reg_rd,
  input wire [`DCFG_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  // alarm inputs and mask
  input wire dacclk_gone,
  input wire dataclk_gone,
  input wire fifo_collision,
  input wire [15:0] alarm_mask_register,
  // transmit enable pin
  input wire tx_enable_pin,
  // input data path
  input wire [DW-1:0] data_in,
  output reg [DW-1:0] data_out,
  // decoded controls
  output wire input_word_wide_sel,
  output wire four_wire_port_sel,
  output wire mixer_enable,
  output wire mixer_gain_6db,
  output wire osc_enable,
  output wire coarse_mix_enable,
  output wire twos_complement_sel,
  output wire [3:0] full_scale_code,
  output wire [4:0] full_scale_steps,
  output wire tx_enable,
  output wire output_shutdown
);
  // ****************
  // registers
  // ****************
  wire [15:0] ctrl;
  wire [15:0] scale;
  wire wr_ctrl;
  wire wr_scale;
  wire pin_tx;
  wire [DW-1:0] rev_in;
  wire [DW-1:0] sel_in;
  wire sd_dacclk;
  wire sd_dataclk;
  wire sd_coll;
  reg sd_latch;
  assign wr_ctrl = reg_wr && (reg_addr == `DCFG_ADDR_CTRL);
  assign wr_scale = reg_wr && (reg_addr == `DCFG_ADDR_SCALE);
  // control register, reserved bits masked
  dcfg_reg16 #(
    .RST_VAL(`DCFG_CTRL_RST),
    .WMASK(`DCFG_CTRL_WMASK)
  ) u_ctrl (
    .clock(clock),
    .sys_rst(sys_rst),
    .wr_en(wr_ctrl),
    .wr_data(reg_wdata),
    .value(ctrl)
  );
  // scale and software transmit enable register
  dcfg_reg16 #(
    .RST_VAL(`DCFG_SCALE_RST),
    .WMASK(`DCFG_SCALE_WMASK)
  ) u_scale (
    .clock(clock),
    .sys_rst(sys_rst),
    .wr_en(wr_scale),
    .wr_data(reg_wdata),
    .value(scale)
  );
  // ****************
  // read back
  // ****************
  // unmapped addresses read as zero
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `DCFG_ADDR_CTRL: reg_rdata <= ctrl;
        `DCFG_ADDR_SCALE: reg_rdata <= scale;
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end
  // ****************
  // decoded controls
  // ****************
  assign input_word_wide_sel = ctrl[`DCFG_B_WORD_WIDE];
  assign four_wire_port_sel = ctrl[`DCFG_B_FOUR_WIRE];
  assign mixer_enable = ctrl[`DCFG_B_MIX_ENA];
  assign mixer_gain_6db = ctrl[`DCFG_B_MIX_GAIN];
  assign osc_enable = ctrl[`DCFG_B_MIX_ENA] & ctrl[`DCFG_B_OSC_ENA];
  // coarse mixing needs only the mixer, not the oscillator
  assign coarse_mix_enable = ctrl[`DCFG_B_MIX_ENA];
  assign twos_complement_sel = ctrl[`DCFG_B_TWOS];
  assign full_scale_code =
    scale[`DCFG_F_SCALE_HI:`DCFG_F_SCALE_LO];
  // current proportional to code plus one
  assign full_scale_steps = {1'b0, full_scale_code} + 5'h01;
  // ****************
  // transmit enable
  // ****************
  dcfg_sync2 u_tx_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .din(tx_enable_pin),
    .dout(pin_tx)
  );
  assign tx_enable = scale[`DCFG_B_SW_TX] | pin_tx;
  // ****************
  // output shutdown
  // ****************
  // each source needs its own alarm and the output alarm unmasked
  assign sd_dacclk = ctrl[`DCFG_B_DACCLK_SD] & dacclk_gone &
    ~alarm_mask_register[`DCFG_M_DACCLK] &
    ~alarm_mask_register[`DCFG_M_OUTPUT];
  assign sd_dataclk = ctrl[`DCFG_B_DATACLK_SD] & dataclk_gone &
    ~alarm_mask_register[`DCFG_M_DATACLK] &
    ~alarm_mask_register[`DCFG_M_OUTPUT];
  assign sd_coll = ctrl[`DCFG_B_COLL_SD] & fifo_collision &
    ~alarm_mask_register[`DCFG_M_COLL] &
    ~alarm_mask_register[`DCFG_M_OUTPUT];
  // shutdown holds until the cause is gone and the control register is rewritten
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      sd_latch <= 1'b0;
    else if (sd_dacclk | sd_dataclk | sd_coll)
      sd_latch <= 1'b1;
    else if (wr_ctrl)
      sd_latch <= 1'b0;
  end
  assign output_shutdown = sd_latch;
  // ****************
  // input data capture
  // ****************
  genvar i;
  generate
    for (i = 0; i < DW; i = i + 1)
    begin : g_rev
      assign rev_in[i] = data_in[DW-1-i];
    end
  endgenerate
  assign sel_in = ctrl[`DCFG_B_REV_BUS] ? rev_in : data_in;
  // offset binary converted to two's complement by msb flip
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      data_out <= {DW{1'b0}};
    else if (ctrl[`DCFG_B_TWOS])
      data_out <= sel_in;
    else
      data_out <= {~sel_in[DW-1], sel_in[DW-2:0]};
  end
endmodule // dcfg_regs

// >>> verif/dcfg_regs_asserts.sv
// checker for the configuration pair ports
// assumes it is bound onto every dcfg_regs
`timescale 1ns/1ps
`include "dcfg_map.vh"
module dcfg_asserts
(
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // register port
  input wire reg_wr,
  input wire [`DCFG_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  // pin and controls
  input wire tx_enable_pin,
  input wire input_word_wide_sel,
  input wire four_wire_port_sel,
  input wire mixer_enable,
  input wire mixer_gain_6db,
  input wire coarse_mix_enable,
  input wire twos_complement_sel,
  input wire [3:0] full_scale_code,
  input wire [4:0] full_scale_steps,
  input wire tx_enable
);
  // write strobes per register
  wire wc = reg_wr && reg_addr == `DCFG_ADDR_CTRL;
  wire ws = reg_wr && reg_addr == `DCFG_ADDR_SCALE;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  a_word_wide: assert property (
    wc |=> input_word_wide_sel == $past(reg_wdata[15]))
    else $error("word width select wrong");
  a_four_wire: assert property (
    wc |=> four_wire_port_sel == $past(reg_wdata[7]))
    else $error("port format select wrong");
  a_mixer_bits: assert property (
    wc |=> {mixer_enable, mixer_gain_6db} == $past(reg_wdata[6:5]))
    else $error("mixer bits wrong");
  a_coarse_mix: assert property (
    wc && reg_wdata[6] |=> coarse_mix_enable)
    else $error("coarse mix tied to oscillator");
  a_twos_sel: assert property (
    wc |=> twos_complement_sel == $past(reg_wdata[1]))
    else $error("format select wrong");
  a_scale_code: assert property (
    ws |=> full_scale_code == $past(reg_wdata[15:12]))
    else $error("scale code wrong");
  a_scale_steps: assert property (
    full_scale_steps == full_scale_code + 5'h01)
    else $error("step count wrong");
  a_tx_soft: assert property (
    ws && reg_wdata[0] |=> tx_enable)
    else $error("soft transmit enable lost");
  a_tx_pin: assert property (
    tx_enable_pin [*3] |-> tx_enable)
    else $error("pin transmit enable lost");
endmodule // dcfg_asserts
bind dcfg_regs dcfg_asserts u_chk (.*);

// >>> verif/dcfg_host.sv
// host model for the register port and transmit pin
// assumes callers are at a falling edge
`timescale 1ns/1ps
`include "dcfg_map.vh"
module dcfg_host
(
  // clock
  input wire clock,
  // register port
  output reg reg_wr = 1'b0,
  output reg reg_rd = 1'b0,
  output reg [`DCFG_ADDR_W-1:0] reg_addr = 7'h7F,
  output reg [15:0] reg_wdata = 16'h0000,
  input wire [15:0] reg_rdata,
  // transmit pin
  output reg tx_enable_pin = 1'b0
);
  // one word write, released lines inverted
  task wr(input [6:0] a, input [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // one word read, data held until next read
  task rd(input [6:0] a, output [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge clock);
    d = reg_rdata;
  endtask
  // pin level, ored with soft enable
  task pin(input v);
    tx_enable_pin = v;
  endtask
endmodule // dcfg_host

// >>> verif/dcfg_regs_tb_top.sv
// bench for the configuration register pair
// assumes host model and checker compiled first
`timescale 1ns/1ps
`include "dcfg_map.vh"
module dcfg_regs_tb_top;
  reg clock = 1'b0;
  reg sys_rst = 1'b0;
  reg [2:0] src = 3'h0;
  reg [15:0] alarm_mask_register = 16'h0000;
  reg [15:0] data_in = 16'h0000;
  reg [15:0] rd;
  wire reg_wr, reg_rd, tx_enable_pin, input_word_wide_sel;
  wire four_wire_port_sel, mixer_enable, mixer_gain_6db, osc_enable;
  wire coarse_mix_enable, twos_complement_sel, tx_enable;
  wire output_shutdown;
  wire [6:0] reg_addr;
  wire [15:0] reg_wdata, reg_rdata, data_out;
  wire [3:0] full_scale_code;
  wire [4:0] full_scale_steps;
  wire [6:0] ctl = {input_word_wide_sel, four_wire_port_sel,
    mixer_enable, mixer_gain_6db, osc_enable, coarse_mix_enable,
    twos_complement_sel};
  integer err_total = 0;
  integer n_compared = 0;
  integer i;
  dcfg_regs u_dut (.*, .dacclk_gone(src[2]), .dataclk_gone(src[1]),
    .fifo_collision(src[0]));
  dcfg_host u_host (.*);
  // clock at 40 MHz
  initial
  begin
    forever #12.5 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      err_total = err_total + 1;
      $display("MISMATCH %0s exp %h got %h", nm, e, g);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task t_reset;
    u_host.rd(`DCFG_ADDR_CTRL, rd);
    chk("ctrl", 16'h7000, rd);
    u_host.rd(`DCFG_ADDR_SCALE, rd);
    chk("scale", 16'hF000, rd);
  endtask
  task t_fields;
    u_host.wr(`DCFG_ADDR_CTRL, 16'hFFFF);
    u_host.rd(`DCFG_ADDR_CTRL, rd);
    chk("ctrl", 16'hF0FA, rd);
    chk("ctl", 16'h007F, ctl);
    u_host.wr(`DCFG_ADDR_CTRL, 16'h0040);
    chk("ctl", 16'h0012, ctl);
    u_host.wr(`DCFG_ADDR_CTRL, 16'h000A);
    data_in = 16'h0003;
    @(negedge clock);
    chk("dout", 16'hC000, data_out);
    u_host.wr(`DCFG_ADDR_CTRL, 16'h0000);
    @(negedge clock);
    chk("dout", 16'h8003, data_out);
  endtask
  task t_scale;
    for (i = 0; i < 16; i = i + 1)
    begin
      u_host.wr(`DCFG_ADDR_SCALE, {i[3:0], 12'h000});
      chk("steps", i + 1, full_scale_steps);
    end
    u_host.wr(`DCFG_ADDR_SCALE, 16'hFFFF);
    u_host.rd(`DCFG_ADDR_SCALE, rd);
    chk("scale", 16'hF001, rd);
    chk("tx", 16'h0001, tx_enable);
    u_host.wr(`DCFG_ADDR_SCALE, 16'hF000);
    u_host.pin(1'b1);
    repeat (3) @(negedge clock);
    chk("tx", 16'h0001, tx_enable);
    u_host.pin(1'b0);
    repeat (3) @(negedge clock);
    chk("tx", 16'h0000, tx_enable);
    u_host.wr(7'h05, 16'hFFFF);
    u_host.rd(7'h05, rd);
    chk("unmap", 16'h0000, rd);
  endtask
  // one alarm trial, ctrl write clears the latch first
  task sd(input [2:0] s, input [15:0] c, input e);
    u_host.wr(`DCFG_ADDR_CTRL, c);
    src = s;
    repeat (2) @(negedge clock);
    chk("shut", e, output_shutdown);
    src = 3'h0;
  endtask
  task t_shut;
    for (i = 0; i < 3; i = i + 1)
    begin
      alarm_mask_register = (i == 2) ? 16'h2000 : 16'h0400 >> i;
      sd(3'h4 >> i, 16'h7000, 1'b0);
      alarm_mask_register = 16'h0100;
      sd(3'h4 >> i, 16'h7000, 1'b0);
      alarm_mask_register = 16'h0000;
      sd(3'h4 >> i, 16'h7000 ^ (16'h4000 >> i), 1'b0);
      sd(3'h4 >> i, 16'h7000, 1'b1);
    end
  endtask
  // main sequence, reset raised after time zero so the edge is seen
  initial
  begin
    #5;
    sys_rst = 1'b1;
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    t_reset;
    t_fields;
    t_scale;
    t_shut;
    // mid-run reset drops the latched shutdown and reloads defaults
    sys_rst = 1'b1;
    @(negedge clock);
    sys_rst = 1'b0;
    chk("shut", 16'h0000, output_shutdown);
    t_reset;
    test_done;
  end
  // watchdog
  initial
  begin
    #40000;
    err_total = err_total + 1;
    test_done;
  end
endmodule // dcfg_regs_tb_top
